/* core/timer_io_pkg.sv */
package timer_io_pkg;

  // Counter and general register width
  localparam int COUNT_W = 16;
  localparam int CHANNELS = 4;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_MODE = 16'hFFD1;
  localparam logic [15:0] IDX_IO_HIGH = 16'hFFD2;
  localparam logic [15:0] IDX_IO_LOW = 16'hFFD3;
  localparam logic [15:0] IDX_GR_BASE = 16'hFFE0;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hFFE4;
  localparam logic [15:0] IDX_IRQ_ENABLE = 16'hFFE5;
  localparam logic [15:0] IDX_IRQ_CLEAR = 16'hFFE6;

  // Field positions
  localparam int FIELD_A_POS = 0;
  localparam int FIELD_B_POS = 4;
  localparam int FIELD_C_POS = 0;
  localparam int FIELD_D_POS = 4;
  localparam int BUFFER_MODE_A_POS = 4;
  localparam int BUFFER_MODE_B_POS = 5;

  // Reset values
  localparam logic [7:0] IO_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'hC0;
  localparam logic [7:0] MODE_FIXED_ONES = 8'hC0;

  // Output compare actions on the low field bits
  localparam logic [1:0] OC_OFF = 2'h0;
  localparam logic [1:0] OC_LOW = 2'h1;
  localparam logic [1:0] OC_HIGH = 2'h2;
  localparam logic [1:0] OC_TOGGLE = 2'h3;

  // AHB-Lite constants
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
  } ahb_in_type;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic [1:0] hresp;
  } ahb_out_type;

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sync_state_type;

  typedef struct packed {
    logic eq_prev;
    logic level;
    logic oe_n;
  } unit_state_type;

  typedef struct packed {
    logic ph_valid;
    logic ph_write;
    logic [29:0] ph_word;
    logic [7:0] io_high;
    logic [7:0] io_low;
    logic [7:0] mode;
    logic [CHANNELS-1:0][COUNT_W-1:0] gr;
    logic [CHANNELS-1:0] status;
    logic [CHANNELS-1:0] enable;
    logic [CHANNELS-1:0] field_load;
    logic irq;
    logic ready;
    logic [31:0] hrdata;
  } top_state_type;

  localparam sync_state_type SYNC_RESET = '{meta: 1'b0, sync: 1'b0, last: 1'b0};
  localparam unit_state_type UNIT_RESET = '{eq_prev: 1'b1, level: 1'b0, oe_n: 1'b1};

endpackage

/* core/pin_sync_edge.sv */
module pin_sync_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic rise,
  output logic fall
);
  import timer_io_pkg::*;

  sync_state_type r_reg;
  sync_state_type r_next;

  // Two stages before use; meta feeds only the second stage
  always_comb begin
    r_next = r_reg;
    r_next.meta = pin_in;
    r_next.sync = r_reg.meta;
    r_next.last = r_reg.sync;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_reg <= SYNC_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // Edges seen on the settled copy only
  assign rise = r_reg.sync & ~r_reg.last;
  assign fall = ~r_reg.sync & r_reg.last;

endmodule

/* core/capture_compare_unit.sv */
module capture_compare_unit (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] field,
  input wire logic disabled,
  input wire logic field_load,
  input wire logic [timer_io_pkg::COUNT_W-1:0] counter,
  input wire logic [timer_io_pkg::COUNT_W-1:0] compare_value,
  input wire logic pin_rise,
  input wire logic pin_fall,
  output logic capture_event,
  output logic match_event,
  output logic pin_level,
  output logic pin_oe_n
);
  import timer_io_pkg::*;

  unit_state_type r_reg;
  unit_state_type r_next;
  logic oc_mode;
  logic ic_mode;
  logic eq;
  logic edge_hit;

  // Mode decode; prohibited 11xx is neither mode and stays silent
  assign oc_mode = ~field[3]; // RULE_01
  assign ic_mode = field[3] & ~field[2]; // RULE_12
  assign eq = (counter == compare_value);

  // Edge choice for capture
  always_comb begin
    edge_hit = 1'b0;
    if (field[1]) begin
      edge_hit = pin_rise | pin_fall; // RULE_07
    end else if (field[0]) begin
      edge_hit = pin_fall; // RULE_06
    end else begin
      edge_hit = pin_rise; // RULE_05
    end
  end

  // Buffer duty masks every event
  assign capture_event = ic_mode & ~disabled & edge_hit; // RULE_10
  assign match_event = oc_mode & ~disabled & eq & ~r_reg.eq_prev; // RULE_10

  // Match fires once on entry to equality, not every cycle it holds
  always_comb begin
    r_next = r_reg;
    r_next.eq_prev = eq;
    r_next.oe_n = ~(oc_mode & ~disabled & (field[1:0] != OC_OFF)); // RULE_01
    if (field_load && oc_mode) begin
      r_next.level = field[2]; // RULE_01
    end else if (match_event) begin
      case (field[1:0])
        OC_LOW: begin
          r_next.level = 1'b0; // RULE_02
        end
        OC_HIGH: begin
          r_next.level = 1'b1; // RULE_03
        end
        OC_TOGGLE: begin
          r_next.level = ~r_reg.level; // RULE_04
        end
        default: begin
          r_next.level = r_reg.level;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_reg <= UNIT_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  assign pin_level = r_reg.level;
  assign pin_oe_n = r_reg.oe_n;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_INIT_LEVEL: assert property (field_load && !field[3] |=> pin_level == $past(field[2])) // RULE_01
    else $error("initial level not loaded");
  AST_MATCH_LOW: assert property (match_event && !field_load && field[1:0] == 2'b01 |=> !pin_level) // RULE_02
    else $error("match did not drive low");
  AST_MATCH_HIGH: assert property (match_event && !field_load && field[1:0] == 2'b10 |=> pin_level) // RULE_03
    else $error("match did not drive high");
  AST_TOGGLE: assert property (match_event && !field_load && field[1:0] == 2'b11
    |=> pin_level != $past(pin_level)) // RULE_04
    else $error("match did not toggle");
  AST_CAP_RISE: assert property (pin_rise && field == 4'b1000 && !disabled |-> capture_event) // RULE_05
    else $error("rising edge not captured");
  AST_CAP_FALL: assert property (pin_fall && field == 4'b1001 && !disabled // RULE_06
    |-> capture_event)
    else $error("falling edge not captured");
  // Falling-edge code must ignore a rising edge
  AST_FALL_ONLY: assert property (pin_rise && !pin_fall && field == 4'b1001 // RULE_06
    |-> !capture_event)
    else $error("rising edge captured in falling-edge mode");
  AST_CAP_BOTH: assert property ((pin_rise || pin_fall) && field[3:1] == 3'b101 && !disabled
    |-> capture_event) // RULE_07
    else $error("edge not captured in both-edge mode");
  AST_BUF_QUIET: assert property (disabled [*2] |-> !capture_event && !match_event && pin_oe_n) // RULE_10
    else $error("buffer register produced an event or drove its pin");

endmodule

/* core/timer_channel_io_control.sv */
//  Function
// (RULE_01) Top bit zero: compare, bit2 initial level
// (RULE_02) Low bits 01: match drives pin low
// (RULE_03) Low bits 10: match drives pin high
// (RULE_04) Low bits 11: match toggles pin
// (RULE_05) Field 1000: capture on rising pin edge
// (RULE_06) Field 1001: capture on falling pin edge
// (RULE_07) Field 101x: capture on both edges
// (RULE_08) Buffer mode A silences register C
// (RULE_09) Buffer mode B silences register D
// (RULE_10) Buffer register only holds, ignores field; its unit still reloads pin level from bit2 on a field write
// (RULE_11) Buffer modes pair A with C, B with D
// (RULE_12) Software never writes field 11xx
// (RULE_13) Reset clears all four I/O fields
//
// Decided for this implementation: register access over AHB-Lite.
module timer_channel_io_control (
  input wire logic clk,
  input wire logic rst_n,
  input wire timer_io_pkg::ahb_in_type ahb_in,
  output timer_io_pkg::ahb_out_type ahb_out,
  input wire logic [timer_io_pkg::COUNT_W-1:0] counter_value,
  input wire logic [timer_io_pkg::CHANNELS-1:0] timer_pin_in,
  output logic [timer_io_pkg::CHANNELS-1:0] timer_pin_out,
  output logic [timer_io_pkg::CHANNELS-1:0] timer_pin_oe_n,
  output logic irq
);
  import timer_io_pkg::*;

  top_state_type r_reg;
  top_state_type r_next;
  logic [CHANNELS-1:0][3:0] field;
  logic [CHANNELS-1:0] disabled;
  logic [CHANNELS-1:0] pin_rise;
  logic [CHANNELS-1:0] pin_fall;
  logic [CHANNELS-1:0] capture_event;
  logic [CHANNELS-1:0] match_event;
  logic [CHANNELS-1:0] events;
  logic [CHANNELS-1:0] clear_bits;
  logic [7:0] wr_byte;
  logic addr_take;

  // Word index match; the low address bits are ignored
  function automatic logic reg_hit(input logic [29:0] word, input logic [15:0] idx);
    reg_hit = (word == {14'h0000, idx});
  endfunction

  // Fields per general register, in A, B, C, D order
  assign field[0] = r_reg.io_high[FIELD_A_POS +: 4];
  assign field[1] = r_reg.io_high[FIELD_B_POS +: 4];
  assign field[2] = r_reg.io_low[FIELD_C_POS +: 4];
  assign field[3] = r_reg.io_low[FIELD_D_POS +: 4];

  // C and D drop out of compare and capture while they buffer
  assign disabled[0] = 1'b0;
  assign disabled[1] = 1'b0;
  assign disabled[2] = r_reg.mode[BUFFER_MODE_A_POS]; // RULE_08
  assign disabled[3] = r_reg.mode[BUFFER_MODE_B_POS]; // RULE_09

  // One synchroniser and one compare/capture unit per pin
  for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
    pin_sync_edge u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .pin_in(timer_pin_in[i]),
      .rise(pin_rise[i]),
      .fall(pin_fall[i])
    );
    capture_compare_unit u_unit (
      .clk(clk),
      .rst_n(rst_n),
      .field(field[i]),
      .disabled(disabled[i]),
      .field_load(r_reg.field_load[i]),
      .counter(counter_value),
      .compare_value(r_reg.gr[i]),
      .pin_rise(pin_rise[i]),
      .pin_fall(pin_fall[i]),
      .capture_event(capture_event[i]),
      .match_event(match_event[i]),
      .pin_level(timer_pin_out[i]),
      .pin_oe_n(timer_pin_oe_n[i])
    );
  end

  assign events = capture_event | match_event;
  assign wr_byte = ahb_in.hwdata[7:0];
  assign addr_take = ahb_in.hsel & ahb_in.hready & ahb_in.htrans[1];

  // Bus writes, hardware events, then the read mux of the new values
  always_comb begin
    r_next = r_reg;
    r_next.field_load = '0;
    r_next.ready = 1'b1;
    clear_bits = '0;

    // Data phase of a write; field loads align with the new field values
    if (r_reg.ph_valid && r_reg.ph_write) begin
      if (reg_hit(r_reg.ph_word, IDX_IO_HIGH)) begin
        r_next.io_high = wr_byte;
        r_next.field_load[1:0] = 2'b11; // RULE_01
      end
      if (reg_hit(r_reg.ph_word, IDX_IO_LOW)) begin
        r_next.io_low = wr_byte;
        r_next.field_load[3:2] = 2'b11; // RULE_01
      end
      if (reg_hit(r_reg.ph_word, IDX_MODE)) begin
        r_next.mode = wr_byte | MODE_FIXED_ONES;
      end
      for (int i = 0; i < CHANNELS; i++) begin
        if (reg_hit(r_reg.ph_word, IDX_GR_BASE + 16'(i))) begin
          r_next.gr[i] = ahb_in.hwdata[COUNT_W-1:0];
        end
      end
      if (reg_hit(r_reg.ph_word, IDX_IRQ_ENABLE)) begin
        r_next.enable = wr_byte[CHANNELS-1:0];
      end
      if (reg_hit(r_reg.ph_word, IDX_IRQ_CLEAR)) begin
        clear_bits = wr_byte[CHANNELS-1:0];
      end
    end

    // Capture beats a bus write to the same register in the same cycle
    for (int i = 0; i < CHANNELS; i++) begin
      if (capture_event[i]) begin
        r_next.gr[i] = counter_value; // RULE_05
      end
    end

    // Buffer pairs: capture pushes old value down, match pulls buffer up
    for (int k = 0; k < 2; k++) begin
      if (r_reg.mode[BUFFER_MODE_A_POS + k]) begin
        if (capture_event[k]) begin
          r_next.gr[k + 2] = r_reg.gr[k]; // RULE_11
        end
        if (match_event[k]) begin
          r_next.gr[k] = r_reg.gr[k + 2]; // RULE_11
        end
      end
    end

    // Sticky status; a new event wins over a clear in the same cycle
    r_next.status = (r_reg.status & ~clear_bits) | events;
    r_next.irq = |(r_next.status & r_next.enable);

    // Address phase; reads see any write landing in this cycle
    r_next.ph_valid = addr_take;
    r_next.ph_write = ahb_in.hwrite;
    r_next.ph_word = ahb_in.haddr[31:2];
    r_next.hrdata = 32'h00000000;
    if (addr_take && !ahb_in.hwrite) begin
      if (reg_hit(ahb_in.haddr[31:2], IDX_IO_HIGH)) begin
        r_next.hrdata = {24'h000000, r_next.io_high};
      end
      if (reg_hit(ahb_in.haddr[31:2], IDX_IO_LOW)) begin
        r_next.hrdata = {24'h000000, r_next.io_low};
      end
      if (reg_hit(ahb_in.haddr[31:2], IDX_MODE)) begin
        r_next.hrdata = {24'h000000, r_next.mode};
      end
      for (int i = 0; i < CHANNELS; i++) begin
        if (reg_hit(ahb_in.haddr[31:2], IDX_GR_BASE + 16'(i))) begin
          r_next.hrdata = {16'h0000, r_next.gr[i]};
        end
      end
      if (reg_hit(ahb_in.haddr[31:2], IDX_IRQ_STATUS)) begin
        r_next.hrdata = {28'h0000000, r_next.status};
      end
      if (reg_hit(ahb_in.haddr[31:2], IDX_IRQ_ENABLE)) begin
        r_next.hrdata = {28'h0000000, r_next.enable};
      end
    end
  end

  // Synchronous reset; fields come up as compare with pins released
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r_reg.ph_valid <= 1'b0;
      r_reg.ph_write <= 1'b0;
      r_reg.ph_word <= 30'h00000000;
      r_reg.io_high <= IO_RESET; // RULE_13
      r_reg.io_low <= IO_RESET; // RULE_13
      r_reg.mode <= MODE_RESET;
      r_reg.gr <= '0;
      r_reg.status <= '0;
      r_reg.enable <= '0;
      r_reg.field_load <= '0;
      r_reg.irq <= 1'b0;
      r_reg.ready <= 1'b1;
      r_reg.hrdata <= 32'h00000000;
    end else begin
      r_reg <= r_next;
    end
  end

  // Zero wait states, always OKAY
  assign ahb_out.hrdata = r_reg.hrdata;
  assign ahb_out.hreadyout = r_reg.ready;
  assign ahb_out.hresp = HRESP_OKAY;
  assign irq = r_reg.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_cap_a;
    capture_event[0] && !r_reg.mode[BUFFER_MODE_A_POS];
  endsequence

  sequence s_cap_a_buffered;
    capture_event[0] && r_reg.mode[BUFFER_MODE_A_POS];
  endsequence

  AST_CAPTURE_LOAD: assert property (s_cap_a |=> r_reg.gr[0] == $past(counter_value)) // RULE_05
    else $error("capture did not load counter");
  AST_BUF_PUSH: assert property (s_cap_a_buffered
    |=> r_reg.gr[2] == $past(r_reg.gr[0]) && r_reg.gr[0] == $past(counter_value)) // RULE_11
    else $error("buffered capture did not shift A into C");
  AST_BUF_PULL: assert property (match_event[1] && r_reg.mode[BUFFER_MODE_B_POS] && !capture_event[1]
    |=> r_reg.gr[1] == $past(r_reg.gr[3])) // RULE_11
    else $error("buffered match did not load D into B");
  AST_C_SILENT: assert property (r_reg.mode[BUFFER_MODE_A_POS] |-> !events[2]) // RULE_08
    else $error("register C active while buffering");
  AST_D_SILENT: assert property (r_reg.mode[BUFFER_MODE_B_POS] |-> !events[3]) // RULE_09
    else $error("register D active while buffering");
  AST_RESET_FIELDS: assert property ($rose(rst_n) |-> r_reg.io_high == 8'h00 && r_reg.io_low == 8'h00
    && timer_pin_oe_n == 4'hF) // RULE_13
    else $error("fields not cleared by reset");
  AST_STICKY: assert property (events[0] |=> r_reg.status[0] ##1 (r_reg.status[0] || $past(clear_bits[0])))
    else $error("status bit lost");

  // Buffer registers C and D let go of their pins one edge in
  sequence s_buf_a_held;
    r_reg.mode[BUFFER_MODE_A_POS] [*2];
  endsequence

  sequence s_buf_b_held;
    r_reg.mode[BUFFER_MODE_B_POS] [*2];
  endsequence

  AST_C_RELEASED: assert property (s_buf_a_held |-> timer_pin_oe_n[2]) // RULE_10
    else $error("buffer register C still drives its pin");
  AST_D_RELEASED: assert property (s_buf_b_held |-> timer_pin_oe_n[3]) // RULE_10
    else $error("buffer register D still drives its pin");

  // Other half of the pairs: A pulls from C, B pushes into D
  sequence s_match_a_buffered;
    match_event[0] && r_reg.mode[BUFFER_MODE_A_POS];
  endsequence

  sequence s_cap_b_buffered;
    capture_event[1] && r_reg.mode[BUFFER_MODE_B_POS];
  endsequence

  AST_BUF_PULL_A: assert property (s_match_a_buffered // RULE_11
    |=> r_reg.gr[0] == $past(r_reg.gr[2]))
    else $error("buffered match did not load C into A");
  AST_BUF_PUSH_B: assert property (s_cap_b_buffered // RULE_11
    |=> r_reg.gr[3] == $past(r_reg.gr[1]) && r_reg.gr[1] == $past(counter_value))
    else $error("buffered capture did not shift B into D");

  // Field writes land at the data-phase edge and arm the level reload
  sequence s_write_io_high;
    r_reg.ph_valid && r_reg.ph_write && r_reg.ph_word == {14'h0000, IDX_IO_HIGH};
  endsequence

  sequence s_write_io_low;
    r_reg.ph_valid && r_reg.ph_write && r_reg.ph_word == {14'h0000, IDX_IO_LOW};
  endsequence

  AST_IO_HIGH_WRITE: assert property (s_write_io_high // RULE_01
    |=> r_reg.io_high == $past(wr_byte) && r_reg.field_load[1:0] == 2'b11)
    else $error("high I/O control write lost");
  AST_IO_LOW_WRITE: assert property (s_write_io_low // RULE_01
    |=> r_reg.io_low == $past(wr_byte) && r_reg.field_load[3:2] == 2'b11)
    else $error("low I/O control write lost");

  // Register A drives its pin only while compare owns it with an action
  sequence s_a_drives;
    (!field[0][3] && field[0][1:0] != OC_OFF) [*2];
  endsequence

  sequence s_a_quiet;
    (field[0][3] || field[0][1:0] == OC_OFF) [*2];
  endsequence

  AST_A_DRIVES: assert property (s_a_drives |-> !timer_pin_oe_n[0]) // RULE_01
    else $error("compare register A left its pin released");
  AST_A_QUIET: assert property (s_a_quiet |-> timer_pin_oe_n[0]) // RULE_01
    else $error("register A drove its pin without an action");

  // No wait states, so a master never has to guess at a stall
  AST_ZERO_WAIT: assert property (ahb_out.hreadyout && ahb_out.hresp == HRESP_OKAY)
    else $error("bus stalled or answered with an error");
  AST_MODE_ONES: assert property (r_reg.mode[7:6] == 2'b11)
    else $error("fixed mode bits cleared");

  // Interrupt follows the enabled status bits with no extra delay
  AST_IRQ_LEVEL: assert property (irq == |(r_reg.status & r_reg.enable))
    else $error("interrupt out of step with status");

  // Read data falls back to zero when no read was taken
  AST_RDATA_IDLE: assert property (!(addr_take && !ahb_in.hwrite)
    |=> ahb_out.hrdata == 32'h00000000)
    else $error("read data stood without a read");

  // A clear with no new event drops the status bit
  AST_CLEAR_DROPS: assert property (clear_bits[0] && !events[0] |=> !r_reg.status[0])
    else $error("status bit survived its clear");

endmodule

/* tb/timer_pin_model.sv */
module timer_pin_model (
  input wire logic [3:0] ext_level,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe_n,
  output logic [3:0] pin_wire
);
  timeunit 1ns;
  timeprecision 1ns;

  // Far side drives only released pins, so the two never fight
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_wire[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
    end
  end
endmodule

/* tb/test_timer_channel_io_control.sv */
module test_timer_channel_io_control;
  timeunit 1ns;
  timeprecision 1ns;
  import timer_io_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ahb_in_type bus_req = '0;
  ahb_in_type bus_in;
  ahb_out_type ahb_out;
  logic [15:0] counter_value = 16'h0000;
  logic [3:0] ext_level = 4'h0;
  logic [3:0] pin_wire;
  logic [3:0] pin_out;
  logic [3:0] pin_oe_n;
  logic irq;
  int error_cnt = 0;
  int compares = 0;

  always #50 clk = ~clk;

  // Single slave, so its ready is the bus ready
  always_comb begin
    bus_in = bus_req;
    bus_in.hready = ahb_out.hreadyout;
  end

  timer_channel_io_control DUT (.clk(clk), .rst_n(rst_n), .ahb_in(bus_in),
    .ahb_out(ahb_out), .counter_value(counter_value), .timer_pin_in(pin_wire),
    .timer_pin_out(pin_out), .timer_pin_oe_n(pin_oe_n), .irq(irq));
  timer_pin_model far_pins (.ext_level(ext_level), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_wire(pin_wire));

  task automatic report_and_stop();
    $display("counts: %0d compares, %0d errors", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_pins(input logic [3:0] got, input logic [3:0] exp);
    check_word({28'h0, got}, {28'h0, exp});
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Bounded wait; a hung bus ends the run as a failure
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ahb_out.hreadyout !== 1'b1 && n < 50);
    if (ahb_out.hreadyout !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] rdata);
    bus_req.hsel <= 1'b1;
    bus_req.htrans <= 2'h2;
    bus_req.haddr <= {14'h0, idx, 2'h0};
    bus_req.hwrite <= wr;
    bus_req.hsize <= 3'h2;
    wait_ready();
    bus_req.hsel <= 1'b0;
    bus_req.htrans <= 2'h0;
    bus_req.hwdata <= wd;
    wait_ready();
    rdata = ahb_out.hrdata;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, d, r);
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, idx, 32'h0, r);
    check_word(r, exp);
    check_pins({2'h0, ahb_out.hresp}, 4'h0);
  endtask

  // Counter visits a value then returns to idle zero
  task automatic pulse_count(input logic [15:0] v);
    counter_value <= v;
    cycles(3);
    counter_value <= 16'h0000;
    cycles(3);
  endtask

  task automatic test_reset();
    check_pins(pin_oe_n, 4'hF);
    check_pins(pin_out, 4'h0);
    rd_chk(IDX_IO_HIGH, 32'h0);
    rd_chk(IDX_IO_LOW, 32'h0);
    rd_chk(16'hFF70, 32'h0);
    $display("test_reset done");
  endtask

  // Every compare code, three matches each so toggle shows both ways
  task automatic test_compare();
    logic [3:0] f;
    logic lvl;
    for (int k = 0; k < 8; k++) begin
      f = 4'(k);
      wr(IDX_IO_HIGH, {28'h0, f});
      cycles(2);
      lvl = f[2];
      check_pins({3'h0, pin_oe_n[0]}, {3'h0, f[1:0] == OC_OFF});
      for (int m = 0; m < 3; m++) begin
        if (f[1:0] != OC_OFF) begin
          check_pins({3'h0, pin_out[0]}, {3'h0, lvl});
        end
        pulse_count(16'h0040);
        lvl = (f[1:0] == OC_LOW) ? 1'b0 : (f[1:0] == OC_HIGH) ? 1'b1 : ~lvl;
      end
    end
    $display("test_compare done");
  endtask

  task automatic test_irq();
    wr(IDX_IRQ_CLEAR, 32'hF);
    wr(IDX_IRQ_ENABLE, 32'h1);
    cycles(2);
    check_pins({3'h0, irq}, 4'h0);
    pulse_count(16'h0040);
    check_pins({3'h0, irq}, 4'h1);
    rd_chk(IDX_IRQ_STATUS, 32'h1);
    wr(IDX_IRQ_ENABLE, 32'h0);
    cycles(2);
    check_pins({3'h0, irq}, 4'h0);
    wr(IDX_IRQ_ENABLE, 32'h1);
    cycles(2);
    check_pins({3'h0, irq}, 4'h1);
    wr(IDX_IRQ_CLEAR, 32'h1);
    cycles(2);
    check_pins({3'h0, irq}, 4'h0);
    rd_chk(IDX_IRQ_STATUS, 32'h0);
    $display("test_irq done");
  endtask

  // Buffered register stays silent while the other of C and D still fires
  task automatic test_buffer();
    for (int b = 0; b < 2; b++) begin
      wr(IDX_IRQ_CLEAR, 32'hF);
      wr(IDX_MODE, b ? 32'h20 : 32'h10);
      wr(IDX_IO_LOW, 32'h55);
      cycles(2);
      check_pins({3'h0, pin_oe_n[2 + b]}, 4'h1);
      pulse_count(16'h0060);
      pulse_count(16'h0070);
      rd_chk(IDX_IRQ_STATUS, b ? 32'h4 : 32'h8);
      wr(IDX_MODE, 32'h0);
      wr(IDX_IO_LOW, 32'h55);
      cycles(2);
      check_pins({3'h0, pin_oe_n[2 + b]}, 4'h0);
      check_pins({3'h0, pin_out[2 + b]}, 4'h1);
    end
    $display("test_buffer done");
  endtask

  // Pairs swap roles: one side captures and pushes, the other matches and pulls
  task automatic test_pairing();
    wr(IDX_MODE, 32'h30);
    for (int p = 0; p < 2; p++) begin
      wr(IDX_IO_HIGH, p ? 32'h82 : 32'h28);
      wr(IDX_GR_BASE + 16'(p), 32'h0123);
      wr(IDX_GR_BASE + 16'(p + 2), 32'h0111);
      wr(IDX_GR_BASE + 16'(1 - p), 32'h0050);
      wr(IDX_GR_BASE + 16'(3 - p), 32'h0077);
      wr(IDX_IRQ_CLEAR, 32'hF);
      counter_value <= 16'h0ABC;
      ext_level[p] <= 1'b1;
      cycles(6);
      rd_chk(IDX_GR_BASE + 16'(p), 32'h0ABC);
      rd_chk(IDX_GR_BASE + 16'(p + 2), 32'h0123);
      pulse_count(16'h0050);
      rd_chk(IDX_GR_BASE + 16'(1 - p), 32'h0077);
      check_pins({3'h0, pin_out[1 - p]}, 4'h1);
      rd_chk(IDX_IRQ_STATUS, 32'h3);
      ext_level[p] <= 1'b0;
      cycles(6);
    end
    wr(IDX_MODE, 32'h0);
    $display("test_pairing done");
  endtask

  // Capture codes; six cycles cover the two-stage sync plus edge detect
  task automatic test_capture();
    for (int k = 8; k < 12; k++) begin
      wr(IDX_IO_HIGH, 32'(k));
      cycles(6);
      wr(IDX_GR_BASE, 32'h0);
      counter_value <= 16'h1234;
      ext_level[0] <= 1'b1;
      cycles(6);
      rd_chk(IDX_GR_BASE, k == 9 ? 32'h0 : 32'h1234);
      counter_value <= 16'h2345;
      ext_level[0] <= 1'b0;
      cycles(6);
      rd_chk(IDX_GR_BASE, k == 8 ? 32'h1234 : 32'h2345);
      counter_value <= 16'h0000;
    end
    $display("test_capture done");
  endtask

  // Main sequence; distinct compare values keep registers from colliding
  initial begin
    cycles(3);
    rst_n <= 1'b1;
    test_reset();
    for (int i = 0; i < 4; i++) begin
      wr(IDX_GR_BASE + 16'(i), 32'h40 + 32'(i * 16));
    end
    test_compare();
    test_irq();
    test_buffer();
    test_capture();
    test_pairing();
    report_and_stop();
  end
endmodule
